// ### pkg/pcb_defs.vh
`ifndef PCB_DEFS_VH
`define PCB_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PCB_OFS_PLL_CTRL 5'h00
`define PCB_OFS_PLL_BW 5'h04
`define PCB_OFS_BRK_FLAG 5'h08
`define PCB_OFS_IRQ_STAT 5'h0C
`define PCB_OFS_IRQ_MASK 5'h10
// ----------------------------------------
// pll_control_reg fields
// ----------------------------------------
`define PCB_CTL_IE_BIT 7
`define PCB_CTL_IF_BIT 6
`define PCB_CTL_ON_BIT 5
`define PCB_CTL_BCS_BIT 4
`define PCB_CTL_UNUSED 4'hF
// ----------------------------------------
// pll_bandwidth_reg fields
// ----------------------------------------
`define PCB_BW_AUTO_BIT 7
`define PCB_BW_LOCK_BIT 6
`define PCB_BW_ACQ_BIT 5
// ----------------------------------------
// break_flag_control_reg and irq fields
// ----------------------------------------
`define PCB_BRK_BREAK_CLEAR_ENABLE_BIT 7
`define PCB_IRQ_LOCKCHG_BIT 0
`define PCB_IRQ_STOP_BIT 1
`define PCB_IRQ_WIDTH 2
// ----------------------------------------
// reset values
// ----------------------------------------
`define PCB_RST_CTRL 8'h00
`define PCB_RST_BW 8'h00
`define PCB_RST_BRK 8'h00
`define PCB_RST_MASK 2'h0
// ----------------------------------------
// bus responses
// ----------------------------------------
`define PCB_RESP_OKAY 2'h0
`define PCB_RESP_SLVERR 2'h2
`endif

// ### core/pcb_top.v
// Functional notes
// - stop forces all clock outputs low
// - stop clears base clock select when VCO
// - after stop, crystal/2 drives base; select stays clear
// - break clears allowed when clear-enable set
// - clear-enable zero protects PLL flag in break
// - auto mode: acquisition bit sets within tracking tolerance
// - auto mode: lock bit sets within lock tolerance
// - select one: VCO/2, zero: crystal/2
// - lock change sets flag; enable gates interrupt
// - acquisition bit read-only auto, writable manual
// - lock read-only auto, reads zero manual
`include "pcb_defs.vh"

module pcb_top (
    input wire CLK_SYS_I,
    input wire RESETN_I,
    // clock source ticks, one-cycle enables
    input wire XTAL_TICK_I,
    input wire VCO_TICK_I,
    // cpu and loop status
    input wire STOP_I,
    input wire WAKE_I,
    input wire BREAK_I,
    input wire TRK_TOL_OK_I,
    input wire LOCK_TOL_OK_I,
    // axi4-lite slave
    input wire [4:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output reg S_AXI_AWREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output reg S_AXI_WREADY_O,
    output reg [1:0] S_AXI_BRESP_O,
    output reg S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire [4:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output reg S_AXI_ARREADY_O,
    output reg [31:0] S_AXI_RDATA_O,
    output reg [1:0] S_AXI_RRESP_O,
    output reg S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    // clock outputs and interrupts
    output reg CRYSTAL_CLOCK_OUT_O,
    output reg BASE_CLOCK_OUT_O,
    output reg CLOCKGEN_INTERRUPT_OUT_O,
    output reg STOPPED_O,
    output reg IRQ_O
);

    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;

    // release the async reset through two flops
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire rst_n = rst_sync_reg;

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg pll_interrupt_enable_reg;
    reg pll_interrupt_flag_reg;
    reg pll_on_reg;
    reg base_clock_select_reg;
    reg auto_mode_reg;
    reg lock_reg;
    reg acq_auto_reg;
    reg acq_manual_reg;
    reg break_clear_enable_reg;
    reg [`PCB_IRQ_WIDTH-1:0] irq_stat_reg;
    reg [`PCB_IRQ_WIDTH-1:0] irq_mask_reg;
    reg stop_reg;

    // bus handshake state
    reg aw_held_reg;
    reg w_held_reg;
    reg [4:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function is_mapped;
        input [4:0] addr;
        begin
            is_mapped = (addr == `PCB_OFS_PLL_CTRL) || (addr == `PCB_OFS_PLL_BW) ||
                        (addr == `PCB_OFS_BRK_FLAG) || (addr == `PCB_OFS_IRQ_STAT) ||
                        (addr == `PCB_OFS_IRQ_MASK);
        end
    endfunction

    // ----------------------------------------
    // write channel decode
    // ----------------------------------------
    wire aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    wire w_take = S_AXI_WVALID_I && S_AXI_WREADY_O;
    wire wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID_O;
    wire wr_lane0 = wr_fire && w_strb_reg[0];
    wire wr_ctrl = wr_lane0 && (aw_addr_reg == `PCB_OFS_PLL_CTRL);
    wire wr_bw = wr_lane0 && (aw_addr_reg == `PCB_OFS_PLL_BW);
    wire wr_brk = wr_lane0 && (aw_addr_reg == `PCB_OFS_BRK_FLAG);
    wire wr_mask = wr_lane0 && (aw_addr_reg == `PCB_OFS_IRQ_MASK);
    wire [7:0] wbyte = w_data_reg[7:0];

    // ----------------------------------------
    // read channel decode
    // ----------------------------------------
    wire ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire rd_ctrl = ar_take && (S_AXI_ARADDR_I == `PCB_OFS_PLL_CTRL);
    wire rd_stat = ar_take && (S_AXI_ARADDR_I == `PCB_OFS_IRQ_STAT);
    // clears are honoured outside break, or in break with clear-enable set
    wire clr_allowed = !BREAK_I || break_clear_enable_reg;

    // ----------------------------------------
    // stop mode
    // ----------------------------------------
    // stop holds the generator off until the wake event
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            stop_reg <= 1'b0;
        end else if (STOP_I) begin
            stop_reg <= 1'b1;
        end else if (WAKE_I) begin
            stop_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // pll_control_reg
    // ----------------------------------------
    // select may only be set with pll on; pll cannot drop while selected
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            pll_interrupt_enable_reg <= |(`PCB_RST_CTRL & (8'h01 << `PCB_CTL_IE_BIT));
            pll_on_reg <= 1'b0;
            base_clock_select_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                pll_interrupt_enable_reg <= wbyte[`PCB_CTL_IE_BIT];
                if (wbyte[`PCB_CTL_ON_BIT] || !base_clock_select_reg) begin
                    pll_on_reg <= wbyte[`PCB_CTL_ON_BIT];
                end
                if (pll_on_reg || !wbyte[`PCB_CTL_BCS_BIT]) begin
                    base_clock_select_reg <= wbyte[`PCB_CTL_BCS_BIT];
                end
            end
            // stop drops the vco source; it stays clear until rewritten
            if (STOP_I || stop_reg) begin
                base_clock_select_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pll_bandwidth_reg
    // ----------------------------------------
    // manual acquisition value is kept aside while auto mode runs
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            auto_mode_reg <= 1'b0;
            acq_manual_reg <= 1'b0;
        end else if (wr_bw) begin
            auto_mode_reg <= wbyte[`PCB_BW_AUTO_BIT];
            if (!auto_mode_reg) begin
                acq_manual_reg <= wbyte[`PCB_BW_ACQ_BIT];
            end
        end
    end

    // ----------------------------------------
    // automatic acquisition and lock status
    // ----------------------------------------
    // status follows the loop tolerance detectors only in auto mode
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            acq_auto_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else if (auto_mode_reg && pll_on_reg) begin
            acq_auto_reg <= TRK_TOL_OK_I;
            lock_reg <= LOCK_TOL_OK_I;
        end else begin
            acq_auto_reg <= 1'b0;
            lock_reg <= 1'b0;
        end
    end

    wire lock_next = (auto_mode_reg && pll_on_reg) ? LOCK_TOL_OK_I : 1'b0;
    wire lock_change = auto_mode_reg && (lock_next != lock_reg);

    // ----------------------------------------
    // pll interrupt flag
    // ----------------------------------------
    // a lock change in the same cycle as a clearing read wins
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            pll_interrupt_flag_reg <= 1'b0;
        end else if (lock_change) begin
            pll_interrupt_flag_reg <= 1'b1;
        end else if (!auto_mode_reg) begin
            pll_interrupt_flag_reg <= 1'b0;
        end else if (rd_ctrl && clr_allowed) begin
            pll_interrupt_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // break flag control
    // ----------------------------------------
    // clear-enable resets to zero so the flag is protected by default
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            break_clear_enable_reg <= |(`PCB_RST_BRK & (8'h01 << `PCB_BRK_BREAK_CLEAR_ENABLE_BIT));
        end else if (wr_brk) begin
            break_clear_enable_reg <= wbyte[`PCB_BRK_BREAK_CLEAR_ENABLE_BIT];
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    wire [`PCB_IRQ_WIDTH-1:0] irq_events = {STOP_I && !stop_reg, lock_change};

    // sticky events; a read clears, a new event in that cycle survives
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= {`PCB_IRQ_WIDTH{1'b0}};
            irq_mask_reg <= `PCB_RST_MASK;
        end else begin
            if (rd_stat && clr_allowed) begin
                irq_stat_reg <= irq_events;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_events;
            end
            if (wr_mask) begin
                irq_mask_reg <= wbyte[`PCB_IRQ_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------
    // clock outputs
    // ----------------------------------------
    // crystal and base outputs toggle on their source tick, giving divide by two
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            CRYSTAL_CLOCK_OUT_O <= 1'b0;
            BASE_CLOCK_OUT_O <= 1'b0;
            CLOCKGEN_INTERRUPT_OUT_O <= 1'b0;
            STOPPED_O <= 1'b0;
            IRQ_O <= 1'b0;
        end else begin
            STOPPED_O <= stop_reg;
            IRQ_O <= |(irq_stat_reg & irq_mask_reg);
            if (STOP_I || stop_reg) begin
                CRYSTAL_CLOCK_OUT_O <= 1'b0;
                BASE_CLOCK_OUT_O <= 1'b0;
                CLOCKGEN_INTERRUPT_OUT_O <= 1'b0;
            end else begin
                if (XTAL_TICK_I) begin
                    CRYSTAL_CLOCK_OUT_O <= !CRYSTAL_CLOCK_OUT_O;
                end
                if (base_clock_select_reg ? VCO_TICK_I : XTAL_TICK_I) begin
                    BASE_CLOCK_OUT_O <= !BASE_CLOCK_OUT_O;
                end
                CLOCKGEN_INTERRUPT_OUT_O <= pll_interrupt_flag_reg &&
                                            pll_interrupt_enable_reg && auto_mode_reg;
            end
        end
    end

    // ----------------------------------------
    // axi write channels
    // ----------------------------------------
    // address and data are held independently, then one response
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `PCB_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR_I;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA_I;
                w_strb_reg <= S_AXI_WSTRB_I;
            end
            S_AXI_AWREADY_O <= !aw_held_reg && !aw_take && !S_AXI_BVALID_O;
            S_AXI_WREADY_O <= !w_held_reg && !w_take && !S_AXI_BVALID_O;
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                S_AXI_AWREADY_O <= 1'b0;
                S_AXI_WREADY_O <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= is_mapped(aw_addr_reg) ? `PCB_RESP_OKAY : `PCB_RESP_SLVERR;
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // axi read channel
    // ----------------------------------------
    reg [7:0] rd_byte;
    // read mux; manual mode hides lock and the auto acquisition status
    always @* begin
        rd_byte = 8'h00;
        case (S_AXI_ARADDR_I)
            `PCB_OFS_PLL_CTRL: rd_byte = {pll_interrupt_enable_reg,
                                          pll_interrupt_flag_reg && auto_mode_reg,
                                          pll_on_reg, base_clock_select_reg, `PCB_CTL_UNUSED};
            `PCB_OFS_PLL_BW: rd_byte = {auto_mode_reg, lock_reg && auto_mode_reg,
                                        auto_mode_reg ? acq_auto_reg : acq_manual_reg,
                                        5'h00};
            `PCB_OFS_BRK_FLAG: rd_byte = {break_clear_enable_reg, 7'h00};
            `PCB_OFS_IRQ_STAT: rd_byte = {6'h00, irq_stat_reg};
            `PCB_OFS_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    // answer in the cycle after the address is taken
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= `PCB_RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= !S_AXI_RVALID_O && !ar_take;
            if (ar_take) begin
                S_AXI_ARREADY_O <= 1'b0;
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O <= {24'h000000, rd_byte};
                S_AXI_RRESP_O <= is_mapped(S_AXI_ARADDR_I) ? `PCB_RESP_OKAY :
                                 `PCB_RESP_SLVERR;
            end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

endmodule

// ### bench/pcb_properties.sv
module pcb_properties (
    input wire CLK_SYS_I,
    input wire RESETN_I,
    input wire XTAL_TICK_I,
    input wire VCO_TICK_I,
    input wire STOP_I,
    input wire S_AXI_AWVALID_I,
    input wire S_AXI_AWREADY_O,
    input wire S_AXI_WREADY_O,
    input wire S_AXI_BVALID_O,
    input wire S_AXI_ARVALID_I,
    input wire S_AXI_ARREADY_O,
    input wire S_AXI_RVALID_O,
    input wire CRYSTAL_CLOCK_OUT_O,
    input wire BASE_CLOCK_OUT_O,
    input wire CLOCKGEN_INTERRUPT_OUT_O,
    input wire STOPPED_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESETN_I);
    // ----
    // stop behaviour and clock sources
    // ----
    sequence s_all_low;
        !CRYSTAL_CLOCK_OUT_O && !BASE_CLOCK_OUT_O && !CLOCKGEN_INTERRUPT_OUT_O;
    endsequence
    sequence s_wr_take;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    endsequence
    sequence s_rd_take;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence
    chk_stop_low: assert property (STOP_I |=> s_all_low [*4])
        else $error("clock outputs not held low after stop");
    chk_stop_flag: assert property (STOP_I |-> ##[1:2] STOPPED_O)
        else $error("stopped indication missing");
    chk_xtal_src: assert property ($changed(CRYSTAL_CLOCK_OUT_O) |->
        $past(XTAL_TICK_I) || $past(STOP_I)) else $error("crystal output moved without tick");
    chk_base_src: assert property ($changed(BASE_CLOCK_OUT_O) |->
        $past(XTAL_TICK_I) || $past(VCO_TICK_I) || $past(STOP_I))
        else $error("base output moved without source tick");
    // ----
    // register bus handshakes
    // ----
    chk_rd_answer: assert property (s_rd_take |=> S_AXI_RVALID_O)
        else $error("read answer late");
    chk_wr_answer: assert property (s_wr_take |-> ##[1:6] S_AXI_BVALID_O)
        else $error("write answer late");
    chk_wr_block: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write taken while response pending");
    chk_rd_block: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read taken while response pending");
endmodule

// ### bench/pcb_partner.sv
module pcb_partner #(
    parameter int XT_DIV = 4,
    parameter int VC_DIV = 3,
    parameter int T_TRK = 20,
    parameter int T_LOCK = 40
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire run_i,
    output logic xtal_tick_o,
    output logic vco_tick_o,
    output logic trk_ok_o,
    output logic lock_ok_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int xc;
    int vc;
    int sc;
    // free oscillator edges; loop error shrinks only while running
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xc <= 0;
            vc <= 0;
            sc <= 0;
            xtal_tick_o <= 1'b0;
            vco_tick_o <= 1'b0;
            trk_ok_o <= 1'b0;
            lock_ok_o <= 1'b0;
        end else begin
            xc <= (xc == XT_DIV - 1) ? 0 : xc + 1;
            vc <= (vc == VC_DIV - 1) ? 0 : vc + 1;
            xtal_tick_o <= (xc == XT_DIV - 1);
            vco_tick_o <= (vc == VC_DIV - 1);
            sc <= !run_i ? 0 : (sc < T_LOCK) ? sc + 1 : sc;
            trk_ok_o <= run_i && sc >= T_TRK; // tracking tolerance reached first
            lock_ok_o <= run_i && sc >= T_LOCK;
        end
    end
endmodule

// ### bench/pll_clock_stop_break_control_tb.sv
`include "pcb_defs.vh"
module pll_clock_stop_break_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, stop, wake, brk, run, awv, wv, bready, arv, rready, base_q, xt_q, vt_q;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, d;
    logic [1:0] r;
    wire xt, vt, trk, lck, awrdy, wrdy, bvalid, arrdy, rvalid, cry, base, cgi, stopped, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rd_w;
    logic cry_q;
    int n_mismatch, checks_done, seed, n_base, n_xt, n_vt, i;
    int n_cry, mdl_auto, mdl_acq;
    int tab [8][3] = '{'{`PCB_OFS_PLL_CTRL, 8'h10, 8'h0F}, '{`PCB_OFS_PLL_CTRL, 8'h20, 8'h2F},
        '{`PCB_OFS_PLL_CTRL, 8'h30, 8'h3F}, '{`PCB_OFS_PLL_CTRL, 8'h10, 8'h3F},
        '{`PCB_OFS_PLL_BW, 8'h20, 8'h20}, '{`PCB_OFS_PLL_BW, 8'h40, 8'h00},
        '{`PCB_OFS_BRK_FLAG, 8'h80, 8'h80}, '{`PCB_OFS_BRK_FLAG, 8'h00, 8'h00}};
    pcb_top dut_u (.CLK_SYS_I(clk), .RESETN_I(rst_n), .XTAL_TICK_I(xt), .VCO_TICK_I(vt),
        .STOP_I(stop), .WAKE_I(wake), .BREAK_I(brk), .TRK_TOL_OK_I(trk), .LOCK_TOL_OK_I(lck),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
        .S_AXI_RDATA_O(rd_w), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .CRYSTAL_CLOCK_OUT_O(cry), .BASE_CLOCK_OUT_O(base),
        .CLOCKGEN_INTERRUPT_OUT_O(cgi), .STOPPED_O(stopped), .IRQ_O(irq));
    pcb_partner u_far (.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .xtal_tick_o(xt),
        .vco_tick_o(vt), .trk_ok_o(trk), .lock_ok_o(lck));
    // ----
    // clock, edge counters and watchdog
    // ----
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // counts base output edges against the ticks that caused them
    always @(posedge clk) begin
        if (base !== base_q) n_base++;
        if (cry !== cry_q) n_cry++;
        if (xt_q) n_xt++;
        if (vt_q) n_vt++;
        base_q = base;
        cry_q = cry;
        xt_q = xt;
        vt_q = vt;
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim;
    end
    // ----
    // shared tasks
    // ----
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] dv, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= dv;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awrdy === 1'b1) awv <= 1'b0;
            if (wrdy === 1'b1) wv <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp(bresp, er);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] dq, output logic [1:0] rq);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arrdy === 1'b1) arv <= 1'b0;
        end while (rvalid !== 1'b1);
        dq = rd_w;
        rq = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] x;
        logic [1:0] y;
        rd(a, x, y);
        cmp(x, e);
        cmp(y, `PCB_RESP_OKAY);
    endtask
    task automatic win();
        @(negedge clk);
        n_base = 0;
        n_cry = 0;
        n_xt = 0;
        n_vt = 0;
        repeat (60) @(negedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        {stop, wake, brk, run, awv, wv, bready, arv, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        {n_mismatch, checks_done} = '0;
        seed = 84521;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 5; i++) rdc(5'(i * 4), (i == 0) ? 32'h0F : 32'h00);
        rd(5'h14, d, r);
        cmp(d, 32'h0);
        cmp(r, `PCB_RESP_SLVERR);
        wr(5'h14, 32'hFF, `PCB_RESP_SLVERR);
        for (i = 0; i < 8; i++) begin
            wr(5'(tab[i][0]), tab[i][1], `PCB_RESP_OKAY);
            rdc(5'(tab[i][0]), tab[i][2]);
        end
        win();
        cmp(n_base == n_vt && n_vt > 8, 1);
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        repeat (8) @(posedge clk);
        cmp({cry, base, cgi, stopped}, 4'h1);
        rdc(`PCB_OFS_PLL_CTRL, 32'h2F);
        rdc(`PCB_OFS_IRQ_STAT, 32'h02);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        @(posedge clk);
        win();
        cmp(n_base == n_xt && n_cry == n_xt && n_xt > 8, 1);
        rdc(`PCB_OFS_PLL_CTRL, 32'h2F);
        wr(`PCB_OFS_IRQ_MASK, 32'h01, `PCB_RESP_OKAY);
        wr(`PCB_OFS_PLL_CTRL, 32'hA0, `PCB_RESP_OKAY);
        wr(`PCB_OFS_PLL_BW, 32'h80, `PCB_RESP_OKAY);
        run <= 1'b1;
        repeat (50) @(posedge clk);
        cmp({cgi, irq}, 2'b11);
        rdc(`PCB_OFS_PLL_BW, 32'hE0);
        rdc(`PCB_OFS_PLL_CTRL, 32'hEF);
        rdc(`PCB_OFS_PLL_CTRL, 32'hAF);
        rdc(`PCB_OFS_IRQ_STAT, 32'h01);
        repeat (2) @(posedge clk);
        cmp({cgi, irq}, 2'b00);
        brk <= 1'b1;
        run <= 1'b0;
        repeat (5) @(posedge clk);
        rdc(`PCB_OFS_PLL_CTRL, 32'hEF);
        wr(`PCB_OFS_PLL_CTRL, 32'hA0, `PCB_RESP_OKAY);
        rdc(`PCB_OFS_PLL_CTRL, 32'hEF);
        brk <= 1'b0;
        rdc(`PCB_OFS_PLL_CTRL, 32'hEF);
        rdc(`PCB_OFS_PLL_CTRL, 32'hAF);
        wr(`PCB_OFS_BRK_FLAG, 32'h80, `PCB_RESP_OKAY);
        brk <= 1'b1;
        run <= 1'b1;
        repeat (50) @(posedge clk);
        rdc(`PCB_OFS_PLL_CTRL, 32'hEF);
        rdc(`PCB_OFS_PLL_CTRL, 32'hAF);
        brk <= 1'b0;
        rdc(`PCB_OFS_PLL_CTRL, 32'hAF);
        rdc(`PCB_OFS_IRQ_STAT, 32'h01);
        // random bandwidth writes against a model of mode and stored manual bit
        mdl_auto = 1;
        mdl_acq = 0;
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(`PCB_OFS_PLL_BW, d, `PCB_RESP_OKAY);
            if (mdl_auto == 0) mdl_acq = d[5];
            mdl_auto = d[7];
            rdc(`PCB_OFS_PLL_BW, (mdl_auto != 0) ? 32'hE0 : 32'(mdl_acq << 5));
        end
        end_sim;
    end
endmodule

bind pcb_top pcb_properties u_chk (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
    .XTAL_TICK_I(XTAL_TICK_I), .VCO_TICK_I(VCO_TICK_I), .STOP_I(STOP_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .CRYSTAL_CLOCK_OUT_O(CRYSTAL_CLOCK_OUT_O),
    .BASE_CLOCK_OUT_O(BASE_CLOCK_OUT_O), .CLOCKGEN_INTERRUPT_OUT_O(CLOCKGEN_INTERRUPT_OUT_O),
    .STOPPED_O(STOPPED_O));
